// ===== shared/ssk_consts.svh
/*
 * Named constants for the subtract, skip and set execution block.
 * Assumes inclusion by bare name from design files only.
 */
`ifndef SSK_CONSTS_SVH
`define SSK_CONSTS_SVH

// ------------------------------------------------------------
// Data constants
// ------------------------------------------------------------
`define SSK_BYTE_ONES     8'hFF
`define SSK_BYTE_ZERO     8'h00
`define SSK_DEC_STEP      8'h01
`define SSK_NIB_ZERO      4'h0
`define SSK_NIB_MSB       3
`define SSK_NIB_CARRY     4

// ------------------------------------------------------------
// Flag bit positions in the flag vector
// ------------------------------------------------------------
`define SSK_FLAG_C        0
`define SSK_FLAG_HALF     1
`define SSK_FLAG_Z        2
`define SSK_FLAG_RANGE    3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SSK_WREG_RST      8'h00
`define SSK_FLAGS_RST     4'h0

`endif

// ===== shared/ssk_pkg.sv
/*
 * Types for the subtract, skip and set execution block.
 * Assumes the decoder drives the operation code with this encoding.
 */
package ssk_pkg;

   // ---------------------------------------------------------
   // Operation codes from the decoder
   // ---------------------------------------------------------
   typedef enum logic [2:0] {
      SSK_OP_SUB_BORROW_WREG = 3'h0,
      SSK_OP_SUB_BORROW_MEM  = 3'h1,
      SSK_OP_DEC_SKIP_MEM    = 3'h2,
      SSK_OP_DEC_SKIP_WREG   = 3'h3,
      SSK_OP_SET_BYTE        = 3'h4,
      SSK_OP_SET_BIT         = 3'h5,
      SSK_OP_NONE            = 3'h7
   } ssk_op_t;

   // ---------------------------------------------------------
   // Execution states
   // ---------------------------------------------------------
   typedef enum logic [1:0] {
      SSK_ST_EXEC  = 2'b00,
      SSK_ST_DUMMY = 2'b01
   } ssk_state_t;

endpackage

// ===== verilog/ssk_bit_set.sv
/*
 * Forces one selected bit of a word to one, others pass through.
 * Assumes the index is already range limited by its width.
 */
`timescale 1ns/1ps

module ssk_bit_set #(
   parameter int WIDTH     = 8,
   parameter int IDX_WIDTH = 3
) (
   input  wire logic [WIDTH-1:0]     data_in,
   input  wire logic [IDX_WIDTH-1:0] index_in,
   output logic      [WIDTH-1:0]     data_out
);

   // ---------------------------------------------------------
   // One-hot mask ORed in
   // ---------------------------------------------------------
   wire logic [WIDTH-1:0] one_hot;
   assign one_hot  = {{(WIDTH-1){1'b0}}, 1'b1} << index_in;
   assign data_out = data_in | one_hot;

endmodule

// ===== verilog/ssk_exec.sv
/*
 * Execution datapath for subtract-with-borrow, decrement-and-skip
 * and byte or bit set operations of an 8-bit core.
 * Assumes the decoder presents one operation with its memory operand
 * already read, and that the data memory takes the write strobe.
 */
// Behaviour
// - Borrow subtract into working register, flags
// - Borrow subtract stored to memory, flags
// - Carry clear if negative, else set
// - Decrement memory byte, skip when zero
// - Skip inserts one dummy instruction cycle
// - Decrement into working register, skip zero
// - Byte set writes all ones, no flags
// - Bit set touches one bit only
`timescale 1ns/1ps

`include "ssk_consts.svh"

module ssk_exec
   import ssk_pkg::*;
#(
   parameter int DATA_WIDTH = 8,
   parameter int ADDR_WIDTH = 8,
   parameter int FLAG_COUNT = 4,
   parameter int IDX_WIDTH  = 3
) (
   input  wire logic                  clock_in,
   input  wire logic                  rst_in,
   input  wire logic                  op_valid_in,
   input  wire ssk_op_t               op_code_in,
   input  wire logic [ADDR_WIDTH-1:0] op_addr_in,
   input  wire logic [DATA_WIDTH-1:0] op_operand_in,
   input  wire logic [IDX_WIDTH-1:0]  op_bit_field_in,
   input  wire logic                  wreg_load_in,
   input  wire logic [DATA_WIDTH-1:0] wreg_load_data_in,
   input  wire logic                  flags_load_in,
   input  wire logic [FLAG_COUNT-1:0] flags_load_data_in,
   output logic                       op_ready_out,
   output logic                       dummy_cycle_out,
   output logic                       skip_out,
   output logic                       mem_wr_en_out,
   output logic [ADDR_WIDTH-1:0]      mem_wr_addr_out,
   output logic [DATA_WIDTH-1:0]      mem_wr_data_out,
   output logic [DATA_WIDTH-1:0]      working_register_out,
   output logic [FLAG_COUNT-1:0]      flags_out
);

   // ---------------------------------------------------------
   // State and storage
   // ---------------------------------------------------------
   ssk_state_t            state_reg;
   ssk_state_t            state_next;
   logic [DATA_WIDTH-1:0] wreg_reg;
   logic [DATA_WIDTH-1:0] wreg_next;
   logic [FLAG_COUNT-1:0] flags_reg;
   logic [FLAG_COUNT-1:0] flags_next;
   logic                  mem_wr_en_reg;
   logic                  mem_wr_en_next;
   logic [ADDR_WIDTH-1:0] mem_wr_addr_reg;
   logic [DATA_WIDTH-1:0] mem_wr_data_reg;
   logic [DATA_WIDTH-1:0] mem_wr_data_next;
   logic                  skip_reg;
   logic                  skip_next;

   // ---------------------------------------------------------
   // Operation decode
   // ---------------------------------------------------------
   wire logic take_op;
   wire logic is_sub_w;
   wire logic is_sub_m;
   wire logic is_dec_m;
   wire logic is_dec_w;
   wire logic is_set_byte;
   wire logic is_set_bit;
   wire logic is_sub;

   // Only accepted while not burning a dummy cycle
   assign take_op     = op_valid_in & op_ready_out;
   assign is_sub_w    = take_op & (op_code_in == SSK_OP_SUB_BORROW_WREG);
   assign is_sub_m    = take_op & (op_code_in == SSK_OP_SUB_BORROW_MEM);
   assign is_dec_m    = take_op & (op_code_in == SSK_OP_DEC_SKIP_MEM);
   assign is_dec_w    = take_op & (op_code_in == SSK_OP_DEC_SKIP_WREG);
   assign is_set_byte = take_op & (op_code_in == SSK_OP_SET_BYTE);
   assign is_set_bit  = take_op & (op_code_in == SSK_OP_SET_BIT);
   assign is_sub      = is_sub_w | is_sub_m;

   // ---------------------------------------------------------
   // Borrow subtract arithmetic
   // ---------------------------------------------------------
   wire logic                    borrow_in;
   wire logic [DATA_WIDTH:0]     diff_full;
   wire logic [`SSK_NIB_CARRY:0] diff_nib;
   wire logic [DATA_WIDTH-1:0]   diff;
   wire logic                    sub_c;
   wire logic                    sub_half;
   wire logic                    sub_z;
   wire logic                    sub_range;
   wire logic [FLAG_COUNT-1:0]   sub_flags;
   logic      [FLAG_COUNT-1:0]   sub_flags_v;

   assign borrow_in = ~flags_reg[`SSK_FLAG_C];
   assign diff_full = {1'b0, wreg_reg} - {1'b0, op_operand_in}
                      - {{DATA_WIDTH{1'b0}}, borrow_in};
   // Low nibble with a spare top bit catches the half borrow
   assign diff_nib  = {1'b0, wreg_reg[`SSK_NIB_MSB:0]}
                      - {1'b0, op_operand_in[`SSK_NIB_MSB:0]}
                      - {`SSK_NIB_ZERO, borrow_in};
   assign diff      = diff_full[DATA_WIDTH-1:0];
   assign sub_c     = ~diff_full[DATA_WIDTH];
   assign sub_half  = ~diff_nib[`SSK_NIB_CARRY];
   assign sub_z     = (diff == `SSK_BYTE_ZERO);
   // Signed overflow: operands differ in sign, result sign flips
   assign sub_range = (wreg_reg[DATA_WIDTH-1] ^ op_operand_in[DATA_WIDTH-1])
                      & (wreg_reg[DATA_WIDTH-1] ^ diff[DATA_WIDTH-1]);

   // Flags packed by named position
   always_comb begin
      sub_flags_v = `SSK_FLAGS_RST;
      sub_flags_v[`SSK_FLAG_C]     = sub_c;
      sub_flags_v[`SSK_FLAG_HALF]  = sub_half;
      sub_flags_v[`SSK_FLAG_Z]     = sub_z;
      sub_flags_v[`SSK_FLAG_RANGE] = sub_range;
   end
   assign sub_flags = sub_flags_v;

   // ---------------------------------------------------------
   // Decrement and skip arithmetic
   // ---------------------------------------------------------
   wire logic [DATA_WIDTH-1:0] dec_val;
   wire logic                  dec_zero;
   wire logic                  want_skip;

   assign dec_val   = op_operand_in - `SSK_DEC_STEP;
   assign dec_zero  = (dec_val == `SSK_BYTE_ZERO);
   // Register form skips on same test
   assign want_skip = (is_dec_m | is_dec_w) & dec_zero;

   // ---------------------------------------------------------
   // Single-bit set
   // ---------------------------------------------------------
   wire logic [DATA_WIDTH-1:0] bit_set_val;

   ssk_bit_set #(
      .WIDTH     (DATA_WIDTH),
      .IDX_WIDTH (IDX_WIDTH)
   ) u_bit_set (
      .data_in  (op_operand_in),
      .index_in (op_bit_field_in),
      .data_out (bit_set_val)
   );

   // ---------------------------------------------------------
   // Destination selection
   // ---------------------------------------------------------
   // Memory destination for memory-form borrow subtract and decrement, byte set and bit set
   assign mem_wr_en_next   = is_sub_m | is_dec_m | is_set_byte | is_set_bit;
   assign mem_wr_data_next = is_sub_m    ? diff :
                             is_dec_m    ? dec_val :
                             is_set_byte ? `SSK_BYTE_ONES :
                             bit_set_val;

   assign wreg_next  = is_sub_w     ? diff :
                       is_dec_w     ? dec_val :
                       wreg_load_in ? wreg_load_data_in :
                       wreg_reg;

   // Only borrow subtract touches flags; decrement and set keep them
   assign flags_next = is_sub        ? sub_flags :
                       flags_load_in ? flags_load_data_in :
                       flags_reg;

   // ---------------------------------------------------------
   // Skip sequencing
   // ---------------------------------------------------------
   // One dummy cycle after a skip
   always_comb begin
      state_next = state_reg;
      skip_next  = 1'b0;
      case (state_reg)
         SSK_ST_EXEC: begin
            if (want_skip) begin
               state_next = SSK_ST_DUMMY;
               skip_next  = 1'b1;
            end
         end
         SSK_ST_DUMMY: begin
            state_next = SSK_ST_EXEC;
         end
         default: begin
            state_next = SSK_ST_EXEC;
         end
      endcase
   end

   // Fetched instruction is discarded while the dummy runs
   assign op_ready_out    = (state_reg == SSK_ST_EXEC);
   assign dummy_cycle_out = (state_reg == SSK_ST_DUMMY);

   // ---------------------------------------------------------
   // State registers
   // ---------------------------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= SSK_ST_EXEC;
         skip_reg  <= 1'b0;
         wreg_reg  <= `SSK_WREG_RST;
         flags_reg <= `SSK_FLAGS_RST;
      end else begin
         state_reg <= state_next;
         skip_reg  <= skip_next;
         wreg_reg  <= wreg_next;
         flags_reg <= flags_next;
      end
   end

   // ---------------------------------------------------------
   // Memory write port registers
   // ---------------------------------------------------------
   // Strobe is a single-cycle pulse; address and data hold after
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         mem_wr_en_reg   <= 1'b0;
         mem_wr_addr_reg <= {ADDR_WIDTH{1'b0}};
         mem_wr_data_reg <= `SSK_BYTE_ZERO;
      end else begin
         mem_wr_en_reg <= mem_wr_en_next;
         if (mem_wr_en_next) begin
            mem_wr_addr_reg <= op_addr_in;
            mem_wr_data_reg <= mem_wr_data_next;
         end
      end
   end

   // ---------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------
   assign skip_out             = skip_reg;
   assign mem_wr_en_out        = mem_wr_en_reg;
   assign mem_wr_addr_out      = mem_wr_addr_reg;
   assign mem_wr_data_out      = mem_wr_data_reg;
   assign working_register_out = wreg_reg;
   assign flags_out            = flags_reg;

endmodule

// ===== verif/ssk_exec_checker.sv
/*
 * Port-level assertions for the subtract, skip and set block.
 * Assumes it is bound to ssk_exec and sees only its ports.
 */
`timescale 1ns/1ps

module ssk_exec_checker
   import ssk_pkg::*;
(
   input wire logic       clock_in,
   input wire logic       rst_in,
   input wire logic       op_valid_in,
   input wire ssk_op_t    op_code_in,
   input wire logic [7:0] op_addr_in,
   input wire logic [7:0] op_operand_in,
   input wire logic [2:0] op_bit_field_in,
   input wire logic       wreg_load_in,
   input wire logic [7:0] wreg_load_data_in,
   input wire logic       flags_load_in,
   input wire logic [3:0] flags_load_data_in,
   input wire logic       op_ready_out,
   input wire logic       dummy_cycle_out,
   input wire logic       skip_out,
   input wire logic       mem_wr_en_out,
   input wire logic [7:0] mem_wr_addr_out,
   input wire logic [7:0] mem_wr_data_out,
   input wire logic [7:0] working_register_out,
   input wire logic [3:0] flags_out
);
   // ------------------------------------------------------------
   // Helpers and properties
   // ------------------------------------------------------------
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);

   // Nine-bit difference, top bit set means a borrow out
   wire       take_w = op_valid_in & op_ready_out;
   wire       dflt_w = take_w & ~flags_load_in;
   wire [8:0] diff_w = {1'b0, working_register_out} - {1'b0, op_operand_in}
                       - {8'h00, ~flags_out[0]};

   property p_sub_wreg;
      take_w && op_code_in == SSK_OP_SUB_BORROW_WREG |=> !mem_wr_en_out
         && working_register_out == $past(diff_w[7:0])
         && flags_out[2] == (working_register_out == 8'h00);
   endproperty
   a_sub_wreg: assert property (p_sub_wreg) else $error("borrow sub to wreg wrong");
   property p_sub_mem;
      take_w && op_code_in == SSK_OP_SUB_BORROW_MEM |=> mem_wr_en_out
         && mem_wr_data_out == $past(diff_w[7:0]) && mem_wr_addr_out == $past(op_addr_in)
         && $stable(working_register_out);
   endproperty
   a_sub_mem: assert property (p_sub_mem) else $error("borrow sub to mem wrong");
   property p_carry;
      take_w && (op_code_in == SSK_OP_SUB_BORROW_WREG || op_code_in == SSK_OP_SUB_BORROW_MEM)
         |=> flags_out[0] == !$past(diff_w[8]);
   endproperty
   a_carry: assert property (p_carry) else $error("carry wrong");
   property p_dec_mem;
      dflt_w && op_code_in == SSK_OP_DEC_SKIP_MEM |=> mem_wr_en_out && $stable(flags_out)
         && mem_wr_data_out == $past(op_operand_in) - 8'h01
         && skip_out == ($past(op_operand_in) == 8'h01);
   endproperty
   a_dec_mem: assert property (p_dec_mem) else $error("dec to mem wrong");
   property p_skip_two;
      skip_out |-> dummy_cycle_out && !op_ready_out ##1 op_ready_out && !skip_out
         && !mem_wr_en_out;
   endproperty
   a_skip_two: assert property (p_skip_two) else $error("skip cycle wrong");
   property p_dec_wreg;
      dflt_w && op_code_in == SSK_OP_DEC_SKIP_WREG |=> !mem_wr_en_out && $stable(flags_out)
         && working_register_out == $past(op_operand_in) - 8'h01
         && skip_out == ($past(op_operand_in) == 8'h01);
   endproperty
   a_dec_wreg: assert property (p_dec_wreg) else $error("dec to wreg wrong");
   property p_set_byte;
      dflt_w && op_code_in == SSK_OP_SET_BYTE |=> mem_wr_en_out && $stable(flags_out)
         && mem_wr_data_out == 8'hFF;
   endproperty
   a_set_byte: assert property (p_set_byte) else $error("set byte wrong");
   property p_set_bit;
      dflt_w && op_code_in == SSK_OP_SET_BIT |=> mem_wr_en_out && $stable(flags_out)
         && mem_wr_data_out == ($past(op_operand_in) | (8'h01 << $past(op_bit_field_in)));
   endproperty
   a_set_bit: assert property (p_set_bit) else $error("set bit wrong");
   property p_no_take;
      !take_w |=> !mem_wr_en_out && !skip_out;
   endproperty
   a_no_take: assert property (p_no_take) else $error("write without op");
endmodule

bind ssk_exec ssk_exec_checker chk_u (
   .clock_in(clock_in), .rst_in(rst_in), .op_valid_in(op_valid_in),
   .op_code_in(op_code_in), .op_addr_in(op_addr_in), .op_operand_in(op_operand_in),
   .op_bit_field_in(op_bit_field_in), .wreg_load_in(wreg_load_in),
   .wreg_load_data_in(wreg_load_data_in), .flags_load_in(flags_load_in),
   .flags_load_data_in(flags_load_data_in), .op_ready_out(op_ready_out),
   .dummy_cycle_out(dummy_cycle_out), .skip_out(skip_out), .mem_wr_en_out(mem_wr_en_out),
   .mem_wr_addr_out(mem_wr_addr_out), .mem_wr_data_out(mem_wr_data_out),
   .working_register_out(working_register_out), .flags_out(flags_out));

// ===== verif/ssk_exec_tb.sv
/*
 * Directed bench for the subtract, skip and set block.
 * Assumes the checker binds itself from its own file.
 */
`timescale 1ns/1ps

module ssk_exec_tb
   import ssk_pkg::*;
;
   logic       clock_in, rst_in, op_valid_in, wreg_load_in, flags_load_in;
   ssk_op_t    op_code_in;
   logic [7:0] op_addr_in, op_operand_in, wreg_load_data_in;
   logic [2:0] op_bit_field_in;
   logic [3:0] flags_load_data_in, flags_out;
   logic       op_ready_out, dummy_cycle_out, skip_out, mem_wr_en_out;
   logic [7:0] mem_wr_addr_out, mem_wr_data_out, working_register_out;
   int         failures, total_checks, cycles;

   ssk_exec dut_u (.clock_in(clock_in), .rst_in(rst_in), .op_valid_in(op_valid_in),
      .op_code_in(op_code_in), .op_addr_in(op_addr_in), .op_operand_in(op_operand_in),
      .op_bit_field_in(op_bit_field_in), .wreg_load_in(wreg_load_in),
      .wreg_load_data_in(wreg_load_data_in), .flags_load_in(flags_load_in),
      .flags_load_data_in(flags_load_data_in), .op_ready_out(op_ready_out),
      .dummy_cycle_out(dummy_cycle_out), .skip_out(skip_out), .mem_wr_en_out(mem_wr_en_out),
      .mem_wr_addr_out(mem_wr_addr_out), .mem_wr_data_out(mem_wr_data_out),
      .working_register_out(working_register_out), .flags_out(flags_out));

   // ------------------------------------------------------------
   // Clock, watchdog and shared tasks
   // ------------------------------------------------------------
   always #10 clock_in = ~clock_in;

   // Whole run is a few dozen cycles, so 2000 means a hang
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         finish_test();
      end
   end

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One op, then an idle cycle; results read just after the taking edge
   task automatic issue(input ssk_op_t code, input logic [7:0] opnd, input logic [2:0] idx);
      @(posedge clock_in);
      op_valid_in     <= 1'b1;
      op_code_in      <= code;
      op_addr_in      <= ~opnd;
      op_operand_in   <= opnd;
      op_bit_field_in <= idx;
      @(posedge clock_in);
      op_valid_in <= 1'b0;
      #1;
   endtask

   // Flags are {range, Z, half, C}; chained so each result seeds the next
   task automatic test_sbc;
      @(posedge clock_in);
      wreg_load_in       <= 1'b1;
      wreg_load_data_in  <= 8'h10;
      flags_load_in      <= 1'b1;
      flags_load_data_in <= 4'h1;
      @(posedge clock_in);
      wreg_load_in  <= 1'b0;
      flags_load_in <= 1'b0;
      issue(SSK_OP_SUB_BORROW_WREG, 8'h20, 3'h0);
      check("wreg", 8'hF0, working_register_out);
      check("flags", 8'h02, 8'(flags_out));
      issue(SSK_OP_SUB_BORROW_WREG, 8'h0F, 3'h0);
      check("wreg", 8'hE0, working_register_out);
      check("flags", 8'h01, 8'(flags_out));
      issue(SSK_OP_SUB_BORROW_WREG, 8'hE0, 3'h0);
      check("flags", 8'h07, 8'(flags_out));
      issue(SSK_OP_SUB_BORROW_MEM, 8'h80, 3'h0);
      check("mem data", 8'h80, mem_wr_data_out);
      check("mem addr", 8'h7F, mem_wr_addr_out);
      check("wreg", 8'h00, working_register_out);
      check("flags", 8'h0A, 8'(flags_out));
      $display("test_sbc done");
   endtask

   // Skip with an op offered in the dummy cycle, which must be dropped
   task automatic test_dec;
      issue(SSK_OP_DEC_SKIP_MEM, 8'h00, 3'h0);
      check("mem data", 8'hFF, mem_wr_data_out);
      check("skip", 8'h00, 8'(skip_out));
      @(posedge clock_in);
      op_valid_in   <= 1'b1;
      op_code_in    <= SSK_OP_DEC_SKIP_MEM;
      op_operand_in <= 8'h01;
      @(posedge clock_in);
      op_code_in <= SSK_OP_SET_BYTE;
      #1;
      check("skip", 8'h01, 8'(skip_out));
      check("ready", 8'h00, 8'(op_ready_out));
      check("mem data", 8'h00, mem_wr_data_out);
      @(posedge clock_in);
      op_valid_in <= 1'b0;
      #1;
      check("mem write", 8'h00, 8'(mem_wr_en_out));
      check("dummy", 8'h00, 8'(dummy_cycle_out));
      issue(SSK_OP_DEC_SKIP_WREG, 8'h01, 3'h0);
      check("wreg", 8'h00, working_register_out);
      check("skip", 8'h01, 8'(skip_out));
      check("mem write", 8'h00, 8'(mem_wr_en_out));
      issue(SSK_OP_DEC_SKIP_WREG, 8'h10, 3'h0);
      check("wreg", 8'h0F, working_register_out);
      check("flags", 8'h0A, 8'(flags_out));
      $display("test_dec done");
   endtask

   task automatic test_set;
      issue(SSK_OP_SET_BYTE, 8'h12, 3'h0);
      check("mem data", 8'hFF, mem_wr_data_out);
      for (int i = 0; i < 8; i++) begin
         issue(SSK_OP_SET_BIT, 8'h42, 3'(i));
         check("mem data", 8'h42 | (8'h01 << i), mem_wr_data_out);
      end
      check("flags", 8'h0A, 8'(flags_out));
      $display("test_set done");
   endtask

   task automatic finish_test;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      clock_in = 1'b0;
      rst_in = 1'b1;
      {op_valid_in, wreg_load_in, flags_load_in} = 3'h0;
      op_code_in = SSK_OP_NONE;
      {op_addr_in, op_operand_in, wreg_load_data_in} = 24'h000000;
      op_bit_field_in = 3'h0;
      flags_load_data_in = 4'h0;
      repeat (3) @(posedge clock_in);
      rst_in <= 1'b0;
      test_sbc();
      test_dec();
      test_set();
      finish_test();
   end
endmodule
